// >>> rtl/pps_framer.sv
// Packet framer: lead-in, marker and buffer start handling, APB registers.
// Assumes a byte modulator with valid/ready, a packet RAM with one-cycle
// read latency, and a demodulated bit stream on the same clock.
`timescale 1ns/100ps
module pps_framer
  import pps_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // Register port
  input  wire pps_apb_req_type apb_i,
  output pps_apb_rsp_type      apb_o,
  // Settings to the checksum engine
  output logic [15:0]          check_polynomial,
  // Transmit byte stream
  output pps_byte_type         tx_o,
  input  wire logic            tx_ready,
  output logic                 tx_header_done,
  // Packet RAM read side
  output logic                 tx_ram_rd,
  output logic [7:0]           tx_ram_addr,
  input  wire logic [7:0]      tx_ram_rdata,
  // Receive bit stream and packet RAM write side
  input  wire logic            rx_bit_valid,
  input  wire logic            rx_bit,
  output pps_ram_wr_type       rx_ram_o
);

  pps_state_type s;
  pps_state_type next_s;
  logic [9:0]    idx;
  logic          acc;
  logic          wr;
  logic          match;
  logic          start_rx;
  logic [8:0]    rd_hit;
  logic [4:0]    mk_len;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  function automatic logic [8:0] reg_read(input logic [9:0] i,
                                          input pps_state_type st);
    if (i == IDX_LEAD) begin
      return {1'b1, st.cfg.lead};
    end else if (i == IDX_POLY_LO) begin
      return {1'b1, st.cfg.poly_lo};
    end else if (i == IDX_POLY_HI) begin
      return {1'b1, st.cfg.poly_hi};
    end else if (i == IDX_MK_CTL) begin
      return {1'b1, st.cfg.mk_ctl};
    end else if (i == IDX_MK_HI) begin
      return {1'b1, st.cfg.mk_hi};
    end else if (i == IDX_MK_MID) begin
      return {1'b1, st.cfg.mk_mid};
    end else if (i == IDX_MK_LO) begin
      return {1'b1, st.cfg.mk_lo};
    end else if (i == IDX_TX_START) begin
      return {1'b1, st.cfg.tx_start};
    end else if (i == IDX_RX_START) begin
      return {1'b1, st.cfg.rx_start};
    end else if (i == IDX_CMD) begin
      return {1'b1, 6'h00, st.rx_en, 1'b0};
    end else if (i == IDX_STAT) begin
      return {1'b1, 6'h00, st.sync_seen, (st.tx_st != TX_IDLE)};
    end else begin
      return {1'b0, RST_BYTE};
    end
  endfunction : reg_read

  assign idx      = apb_i.paddr[11:2];
  assign acc      = apb_i.psel & apb_i.penable;
  assign wr       = acc & apb_i.pwrite;
  assign rd_hit   = reg_read(idx, s);
  assign mk_len   = s.cfg.mk_ctl[LEN_MSB:LEN_LSB];
  assign start_rx = match & s.rx_en & ~s.storing;

  // Zero wait states; read data is captured in the setup cycle
  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = acc & ~rd_hit[8];
  assign apb_o.prdata  = s.rdata;

  assign check_polynomial = {s.cfg.poly_hi, s.cfg.poly_lo};
  assign tx_o             = s.tx;
  assign tx_header_done   = s.hdr_done;
  assign tx_ram_rd        = s.ram_rd;
  assign tx_ram_addr      = s.cfg.tx_start;
  assign rx_ram_o         = s.wr;

  // --------------------------------------------------------------------
  // Marker detector
  // --------------------------------------------------------------------
  pps_marker_match u_match (
    .clk       (clk),
    .rst_b     (rst_b),
    .bit_valid (rx_bit_valid),
    .bit_in    (rx_bit),
    .restart   (~s.rx_en | s.storing),
    .marker    ({s.cfg.mk_hi, s.cfg.mk_mid, s.cfg.mk_lo}),
    .len       (mk_len),
    .allowance (s.cfg.mk_ctl[TOL_MSB:TOL_LSB]),
    .match     (match)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [7:0] base;
    logic [2:0] bc;
    base          = start_rx ? s.cfg.rx_start : s.wr_addr;
    bc            = start_rx ? 3'h0 : s.bit_cnt;
    next_s        = s;
    next_s.ram_rd = 1'b0;
    next_s.hdr_done = 1'b0;
    next_s.wr.wr  = 1'b0;

    if (apb_i.psel & ~apb_i.penable) begin
      next_s.rdata = {24'h000000, rd_hit[7:0]};
    end
    // Reserved control bit is stored as written; software keeps it zero
    if (wr) begin
      if (idx == IDX_LEAD) begin
        next_s.cfg.lead = apb_i.pwdata[7:0];
      end else if (idx == IDX_POLY_LO) begin
        next_s.cfg.poly_lo = apb_i.pwdata[7:0];
      end else if (idx == IDX_POLY_HI) begin
        next_s.cfg.poly_hi = apb_i.pwdata[7:0];
      end else if (idx == IDX_MK_CTL) begin
        next_s.cfg.mk_ctl = apb_i.pwdata[7:0];
      end else if (idx == IDX_MK_HI) begin
        next_s.cfg.mk_hi = apb_i.pwdata[7:0];
      end else if (idx == IDX_MK_MID) begin
        next_s.cfg.mk_mid = apb_i.pwdata[7:0];
      end else if (idx == IDX_MK_LO) begin
        next_s.cfg.mk_lo = apb_i.pwdata[7:0];
      end else if (idx == IDX_TX_START) begin
        next_s.cfg.tx_start = apb_i.pwdata[7:0];
      end else if (idx == IDX_RX_START) begin
        next_s.cfg.rx_start = apb_i.pwdata[7:0];
      end else if (idx == IDX_CMD) begin
        next_s.rx_en = apb_i.pwdata[CMD_RX_EN];
      end else if (idx == IDX_STAT && apb_i.pwdata[STAT_SYNC]) begin
        next_s.sync_seen = 1'b0;
      end
    end

    // Transmit header sequencer
    case (s.tx_st)
      TX_IDLE: begin
        if (wr && idx == IDX_CMD && apb_i.pwdata[CMD_TX_GO]) begin
          next_s.tx_st   = TX_LEAD;
          next_s.cnt     = s.cfg.lead;
          next_s.mk_left = pps_marker_bytes(mk_len);
        end
      end
      TX_LEAD: begin
        if (!(s.tx.valid && !tx_ready)) begin
          if (s.cnt != 8'h00) begin
            next_s.tx.valid = 1'b1;
            next_s.tx.data  = PREAMBLE_BYTE;
            next_s.cnt      = s.cnt - 8'h01;
          end else begin
            next_s.tx.valid = 1'b0;
            next_s.tx_st    = TX_MARK;
          end
        end
      end
      TX_MARK: begin
        if (!(s.tx.valid && !tx_ready)) begin
          if (s.mk_left != 2'h0) begin
            next_s.tx.valid = 1'b1;
            next_s.mk_left  = s.mk_left - 2'h1;
            if (s.mk_left == 2'h3) begin
              next_s.tx.data = s.cfg.mk_hi;
            end else if (s.mk_left == 2'h2) begin
              next_s.tx.data = s.cfg.mk_mid;
            end else begin
              next_s.tx.data = s.cfg.mk_lo;
            end
          end else begin
            next_s.tx.valid = 1'b0;
            next_s.tx_st    = TX_FETCH;
          end
        end
      end
      TX_FETCH: begin
        next_s.ram_rd = 1'b1;
        next_s.tx_st  = TX_WAIT;
      end
      TX_WAIT: begin
        next_s.tx_st = TX_SEND;
      end
      TX_SEND: begin
        next_s.tx.valid = 1'b1;
        next_s.tx.data  = tx_ram_rdata;
        next_s.tx_st    = TX_DRAIN;
      end
      TX_DRAIN: begin
        if (tx_ready) begin
          next_s.tx.valid  = 1'b0;
          next_s.hdr_done  = 1'b1;
          next_s.tx_st     = TX_IDLE;
        end
      end
      default: begin
        next_s.tx_st = TX_IDLE;
      end
    endcase

    // Receive: after a marker match, pack bits MSB first into the RAM
    if (!s.rx_en) begin
      next_s.storing = 1'b0;
    end else if (start_rx || s.storing) begin
      next_s.storing = 1'b1;
      next_s.wr_addr = base;
      next_s.bit_cnt = bc;
      if (rx_bit_valid) begin
        next_s.rx_shift = {s.rx_shift[6:0], rx_bit};
        next_s.bit_cnt  = bc + 3'h1;
        if (bc == 3'h7) begin
          next_s.wr.wr   = 1'b1;
          next_s.wr.addr = base;
          next_s.wr.data = {s.rx_shift[6:0], rx_bit};
          next_s.wr_addr = base + 8'h01;
        end
      end
    end
    // A match in the clearing cycle still leaves the flag set
    if (start_rx) begin
      next_s.sync_seen = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [7:0] lead_sent;
  logic       mark_entry;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lead_sent <= 8'h00;
    end else if (s.tx_st == TX_IDLE) begin
      lead_sent <= 8'h00;
    end else if (s.tx_st == TX_LEAD && s.tx.valid && tx_ready) begin
      lead_sent <= lead_sent + 8'h01;
    end
  end

  assign mark_entry = (s.tx_st == TX_MARK) && !s.tx.valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_lead_len;
    (s.tx_st == TX_LEAD && next_s.tx_st == TX_MARK)
      |=> (lead_sent == $past(s.cfg.lead));
  endproperty
  a_lead_len: assert property (p_lead_len)
    else $error("preamble byte count differs from setting");

  property p_poly_lo;
    (wr && idx == IDX_POLY_LO)
      |=> (check_polynomial[7:0] == $past(apb_i.pwdata[7:0]));
  endproperty
  a_poly_lo: assert property (p_poly_lo)
    else $error("polynomial low byte not taken");

  property p_three_bytes;
    (mark_entry && mk_len > MK_LEN_TWO && s.mk_left == 2'h3)
      |=> (tx_o.valid && tx_o.data == s.cfg.mk_hi);
  endproperty
  a_three_bytes: assert property (p_three_bytes)
    else $error("long marker does not start with high byte");

  property p_two_bytes;
    (s.tx_st == TX_IDLE && next_s.tx_st == TX_LEAD
      && mk_len >= MK_LEN_ONE && mk_len <= MK_LEN_TWO)
      |=> (s.mk_left == 2'h2);
  endproperty
  a_two_bytes: assert property (p_two_bytes)
    else $error("mid-length marker not two bytes");

  property p_one_byte;
    (mark_entry && s.mk_left == 2'h1)
      |=> (tx_o.valid && tx_o.data == s.cfg.mk_lo);
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("last marker byte is not the low byte");

  property p_no_marker;
    (mark_entry && s.mk_left == 2'h0)
      |=> (s.tx_st == TX_FETCH && !tx_o.valid);
  endproperty
  a_no_marker: assert property (p_no_marker)
    else $error("marker sent with zero length");

  sequence s_fetch;
    tx_ram_rd && (tx_ram_addr == s.cfg.tx_start);
  endsequence

  property p_fetch;
    (s.tx_st == TX_FETCH)
      |=> s_fetch ##2 (tx_o.valid && tx_o.data == $past(tx_ram_rdata));
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("payload not fetched from transmit start");

  property p_rx_base;
    $rose(s.storing) |-> (s.wr_addr == $past(s.cfg.rx_start));
  endproperty
  a_rx_base: assert property (p_rx_base)
    else $error("receive store does not start at receive start");

endmodule : pps_framer

// >>> rtl/pps_pkg.sv
// Constants, field layouts and carrier types for the packet framer.
// Assumes a single 40 MHz clock domain and an APB register port.
package pps_pkg;

  // --------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam logic [9:0] IDX_LEAD     = 10'h11D;
  localparam logic [9:0] IDX_POLY_LO  = 10'h11E;
  localparam logic [9:0] IDX_POLY_HI  = 10'h11F;
  localparam logic [9:0] IDX_MK_CTL   = 10'h120;
  localparam logic [9:0] IDX_MK_HI    = 10'h121;
  localparam logic [9:0] IDX_MK_MID   = 10'h122;
  localparam logic [9:0] IDX_MK_LO    = 10'h123;
  localparam logic [9:0] IDX_TX_START = 10'h124;
  localparam logic [9:0] IDX_RX_START = 10'h125;
  localparam logic [9:0] IDX_CMD      = 10'h130;
  localparam logic [9:0] IDX_STAT     = 10'h131;

  // --------------------------------------------------------------------
  // Fields, reset values and fixed patterns
  // --------------------------------------------------------------------
  localparam int         TOL_MSB       = 7;
  localparam int         TOL_LSB       = 6;
  localparam int         LEN_MSB       = 4;
  localparam int         LEN_LSB       = 0;
  localparam int         CMD_TX_GO     = 0;
  localparam int         CMD_RX_EN     = 1;
  localparam int         STAT_TX_BUSY  = 0;
  localparam int         STAT_SYNC     = 1;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [4:0] MK_LEN_MAX    = 5'h18;
  localparam logic [4:0] MK_LEN_TWO    = 5'h10;
  localparam logic [4:0] MK_LEN_ONE    = 5'h08;

  // --------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pps_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pps_apb_rsp_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pps_byte_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pps_ram_wr_type;

  typedef struct packed {
    logic [7:0] lead;
    logic [7:0] poly_lo;
    logic [7:0] poly_hi;
    logic [7:0] mk_ctl;
    logic [7:0] mk_hi;
    logic [7:0] mk_mid;
    logic [7:0] mk_lo;
    logic [7:0] tx_start;
    logic [7:0] rx_start;
  } pps_cfg_type;

  typedef enum logic [2:0] {
    TX_IDLE, TX_LEAD, TX_MARK, TX_FETCH, TX_WAIT, TX_SEND, TX_DRAIN
  } pps_tx_state_type;

  typedef struct packed {
    pps_cfg_type      cfg;
    logic             rx_en;
    logic             sync_seen;
    pps_tx_state_type tx_st;
    logic [7:0]       cnt;
    logic [1:0]       mk_left;
    pps_byte_type     tx;
    logic [31:0]      rdata;
    logic             ram_rd;
    logic             hdr_done;
    logic             storing;
    logic [2:0]       bit_cnt;
    logic [7:0]       rx_shift;
    logic [7:0]       wr_addr;
    pps_ram_wr_type   wr;
  } pps_state_type;

  typedef struct packed {
    logic [23:0] shift;
    logic [4:0]  fill;
  } pps_det_state_type;

  // Number of marker bytes that go on air for a given length
  function automatic logic [1:0] pps_marker_bytes(input logic [4:0] len);
    if (len > MK_LEN_TWO) begin
      return 2'h3;
    end else if (len >= MK_LEN_ONE) begin
      return 2'h2;
    end else if (len != 5'h00) begin
      return 2'h1;
    end else begin
      return 2'h0;
    end
  endfunction : pps_marker_bytes

endpackage : pps_pkg

// >>> rtl/pps_marker_match.sv
// Sliding marker comparator for the receive bit stream.
// Assumes bits arrive from demodulator logic on the same clock.
`timescale 1ns/100ps
module pps_marker_match
  import pps_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Bit stream
  input  wire logic        bit_valid,
  input  wire logic        bit_in,
  input  wire logic        restart,
  // Settings
  input  wire logic [23:0] marker,
  input  wire logic [4:0]  len,
  input  wire logic [1:0]  allowance,
  // Result
  output logic             match
);

  pps_det_state_type s;
  pps_det_state_type next_s;
  logic [23:0]       mask;
  logic [4:0]        errs;

  function automatic logic [4:0] count_ones(input logic [23:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 24; i++) begin
      c = c + {4'h0, v[i]};
    end
    return c;
  endfunction : count_ones

  // Oversize lengths are clamped so no more than the register width counts
  assign mask  = (len >= MK_LEN_MAX) ? 24'hFFFFFF
               : ((24'h000001 << len) - 24'h000001);
  assign errs  = count_ones((s.shift ^ marker) & mask);
  assign match = (len != 5'h00) && (s.fill >= len || s.fill == MK_LEN_MAX)
               && (errs <= {3'h0, allowance});

  always_comb begin
    next_s = s;
    if (restart) begin
      next_s = '0;
    end else if (bit_valid) begin
      next_s.shift = {s.shift[22:0], bit_in};
      if (s.fill < MK_LEN_MAX) begin
        next_s.fill = s.fill + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_len_zero;
    (len == 5'h00) |-> !match;
  endproperty
  a_len_zero: assert property (p_len_zero)
    else $error("marker match with zero length");

  property p_tolerance;
    match |-> ($countones((s.shift ^ marker) & mask) <= allowance);
  endproperty
  a_tolerance: assert property (p_tolerance)
    else $error("marker match beyond mismatch allowance");

endmodule : pps_marker_match

// >>> tb/pps_air_model.sv
// Far-side model: modulator byte sink with stalls, plus the packet RAM.
// Assumes the framer's clock; RAM answers one cycle after a read strobe.
`timescale 1ns/100ps
module pps_air_model
  import pps_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Byte stream
  input  wire pps_byte_type tx_i,
  input  wire logic         stall,
  output logic              tx_ready,
  // Packet RAM
  input  wire logic         ram_rd,
  input  wire logic [7:0]   ram_addr,
  output logic [7:0]        ram_rdata
);
  logic [7:0] got[$];
  logic [7:0] rd_addr[$];

  always @(posedge clk) begin
    if (!rst_b) begin
      tx_ready  <= 1'b0;
      ram_rdata <= 8'hC3;
    end else begin
      tx_ready <= ~stall;
      if (tx_i.valid === 1'b1 && tx_ready) begin
        got.push_back(tx_i.data);
      end
      // Read data lives one cycle; scrambled after so a late sample shows
      if (ram_rd === 1'b1) begin
        ram_rdata <= ram_addr ^ 8'hA5;
        rd_addr.push_back(ram_addr);
      end else begin
        ram_rdata <= ~ram_rdata;
      end
    end
  end
endmodule : pps_air_model

// >>> tb/packet_preamble_sync_config_tb_top.sv
// Self-checking bench for the packet framer: registers, frames, receive.
// Assumes the far-side model in pps_air_model and a 40 MHz clock.
`timescale 1ns/100ps
module packet_preamble_sync_config_tb_top
  import pps_pkg::*;
;
  logic            clk;
  logic            rst_b;
  logic            stall;
  logic            tx_ready;
  logic            tx_header_done;
  logic            tx_ram_rd;
  logic            rx_bit_valid;
  logic            rx_bit;
  pps_apb_req_type apb_i;
  pps_apb_rsp_type apb_o;
  logic [15:0]     check_polynomial;
  pps_byte_type    tx_o;
  logic [7:0]      tx_ram_addr;
  logic [7:0]      tx_ram_rdata;
  pps_ram_wr_type  rx_ram_o;
  int              n_fail;
  int              tests_run;
  int              i;
  logic [31:0]     seed;
  logic [31:0]     sseed;
  logic [31:0]     r;
  logic            e;
  logic [7:0]      v[9];
  logic [15:0]     wq[$];
  logic [4:0]      tl[8] = '{0, 1, 7, 8, 15, 16, 17, 24};
  logic [4:0]      rl[6] = '{24, 24, 24, 12, 5, 1};
  logic [1:0]      rt[6] = '{0, 3, 2, 1, 0, 0};
  int              re[6] = '{0, 3, 3, 1, 0, 0};
  logic            rh[6] = '{1, 1, 0, 1, 1, 1};

  always #12.5 clk = ~clk;

  pps_framer i_dut (.clk(clk), .rst_b(rst_b), .apb_i(apb_i), .apb_o(apb_o),
    .check_polynomial(check_polynomial), .tx_o(tx_o), .tx_ready(tx_ready),
    .tx_header_done(tx_header_done), .tx_ram_rd(tx_ram_rd),
    .tx_ram_addr(tx_ram_addr), .tx_ram_rdata(tx_ram_rdata),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_ram_o(rx_ram_o));

  pps_air_model i_air (.clk(clk), .rst_b(rst_b), .tx_i(tx_o), .stall(stall),
    .tx_ready(tx_ready), .ram_rd(tx_ram_rd), .ram_addr(tx_ram_addr),
    .ram_rdata(tx_ram_rdata));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [1:0] nbytes(input logic [4:0] len);
    if (len > 5'h10) return 2'h3;
    if (len >= 5'h08) return 2'h2;
    return (len != 5'h00) ? 2'h1 : 2'h0;
  endfunction : nbytes

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'h0},
               pwdata: {24'h0, wd}};
    @(posedge clk);
    apb_i.penable <= 1'b1;
    @(posedge clk);
    while (apb_o.pready !== 1'b1) @(posedge clk);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask : apb

  task wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, d, x, y);
  endtask : wr

  task rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, idx, 8'h00, x, y);
    chk(x, {24'h0, exp});
  endtask : rdc

  task sbit(input logic b);
    @(posedge clk);
    rx_bit_valid <= 1'b1;
    rx_bit <= b;
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    rx_bit <= ~b;
  endtask : sbit

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic tx_case(input logic [7:0] lead, input logic [4:0] len);
    logic [23:0] mk;
    logic [23:0] mask;
    logic [7:0]  start;
    logic [7:0]  q[$];
    int          k;
    seed = xs(seed);
    mask = (24'h1 << len) - 24'h1;
    mk = (seed[23:0] & mask) | (24'h555555 & ~mask);
    start = seed[31:24];
    wr(IDX_LEAD, lead);
    wr(IDX_MK_CTL, {3'h0, len});
    wr(IDX_MK_HI, mk[23:16]);
    wr(IDX_MK_MID, mk[15:8]);
    wr(IDX_MK_LO, mk[7:0]);
    wr(IDX_TX_START, start);
    repeat (lead) q.push_back(PREAMBLE_BYTE);
    for (k = nbytes(len); k > 0; k--) q.push_back(mk[8*k-8 +: 8]);
    q.push_back(start ^ 8'hA5);
    i_air.got.delete();
    i_air.rd_addr.delete();
    wr(IDX_CMD, 8'h01);
    k = 0;
    while (tx_header_done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, tx_header_done}, 32'h1);
    chk(i_air.got.size(), q.size());
    foreach (q[j]) chk(i_air.got[j], q[j]);
    chk(i_air.rd_addr[0], start);
    repeat (4) @(posedge clk);
  endtask : tx_case

  task rx_case(input logic [4:0] len, input logic [1:0] tol, input int nerr,
               input logic hit);
    logic [23:0] mk;
    logic [15:0] pl;
    logic [7:0]  start;
    int          k;
    seed = xs(seed);
    mk = seed[23:0];
    start = seed[31:24];
    seed = xs(seed);
    pl = seed[15:0];
    wr(IDX_MK_CTL, {tol, 1'b0, len});
    wr(IDX_MK_HI, mk[23:16]);
    wr(IDX_MK_MID, mk[15:8]);
    wr(IDX_MK_LO, mk[7:0]);
    wr(IDX_RX_START, start);
    wr(IDX_CMD, 8'h02);
    wq.delete();
    for (k = len - 1; k >= 0; k--) sbit(mk[k] ^ (k < nerr));
    if (hit) begin
      for (k = 15; k >= 0; k--) sbit(pl[k]);
    end
    repeat (4) @(posedge clk);
    chk(wq.size(), hit ? 2 : 0);
    if (hit) begin
      chk(wq[0], {start, pl[15:8]});
      chk(wq[1], {start + 8'h01, pl[7:0]});
    end
    rdc(IDX_STAT, {6'h0, hit, 1'b0});
    wr(IDX_CMD, 8'h00);
    wr(IDX_STAT, 8'h02);
  endtask : rx_case

  always @(posedge clk) begin
    sseed <= xs(sseed);
    stall <= sseed[0] & sseed[1];
    if (rx_ram_o.wr === 1'b1) wq.push_back({rx_ram_o.addr, rx_ram_o.data});
  end

  // Whole run is about a thousand cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    apb_i = '0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    stall = 1'b0;
    seed = 32'h5E;
    sseed = 32'h5E;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 9; i++) rdc(10'(IDX_LEAD + i), RST_BYTE);
    for (i = 0; i < 9; i++) begin
      seed = xs(seed);
      v[i] = (i == 3) ? (seed[7:0] & 8'hDF) : seed[7:0];
      wr(10'(IDX_LEAD + i), v[i]);
      rdc(10'(IDX_LEAD + i), v[i]);
    end
    chk({16'h0, check_polynomial}, {16'h0, v[2], v[1]});
    apb(1'b0, 10'h100, 8'h00, r, e);
    chk({r[30:0], e}, 32'h1);
    for (i = 0; i < 11; i++) begin
      seed = xs(seed);
      tx_case(8'(i % 4), (i < 8) ? tl[i] : 5'(seed[7:0] % 25));
    end
    for (i = 0; i < 6; i++) rx_case(rl[i], rt[i], re[i], rh[i]);
    wrap_up;
  end
endmodule : packet_preamble_sync_config_tb_top
